/* File: rtl/iocc_consts.svh */
// Constants for the channel countdown clock: command bits, status bits,
// byte geometry and the host-side register map.
// Assumes it is included by bare name from every file that needs it.
`ifndef IOCC_CONSTS_SVH
`define IOCC_CONSTS_SVH

// Command word fields
`define IOCC_CMD_INT_EN   0
`define IOCC_CMD_AUTO     1
`define IOCC_CMD_BC_LO    2
`define IOCC_CMD_BC_HI    3
`define IOCC_CMD_SAMPLE   4
`define IOCC_CMD_SNAP     5
`define IOCC_CMD_LOAD     6
`define IOCC_CMD_RUN      7
`define IOCC_CFG_W        4

// Byte and count geometry
`define IOCC_BYTE_W       8
`define IOCC_COUNT_W      24
`define IOCC_COUNT_ONE    24'h000001
`define IOCC_COUNT_ZERO   24'h000000

// Device status word bits
`define IOCC_ST_INTR      0
`define IOCC_ST_RUN       1
`define IOCC_ST_SNAP      2
`define IOCC_ST_LOAD      3
`define IOCC_ST_ZERO      4

// Host register map (byte addresses) and fields
`define IOCC_ADDR_W       4
`define IOCC_REG_XFER     4'h0
`define IOCC_REG_STAT     4'h4
`define IOCC_XF_OP_LO     8
`define IOCC_XF_UNIT_LO   10
`define IOCC_HS_BUSY      8
`define IOCC_HS_DONE      9
`define IOCC_HS_INTR      10
`define IOCC_RESP_OKAY    2'h0
`define IOCC_RESP_SLVERR  2'h2

`endif

/* File: rtl/iocc_pkg.sv */
// Types for the host end of the channel countdown clock and its bench.
// Assumes nothing of its surroundings.
package iocc_pkg;

    // Channel operation selected by the host
    typedef enum logic [1:0] {
        command_output_transfer,
        status_input_transfer,
        data_output_transfer,
        data_input_transfer
    } iocc_op_t;

    // Host sequencer state
    typedef enum logic [1:0] {
        hs_idle,
        hs_issue,
        hs_wait
    } iocc_host_state_t;

endpackage : iocc_pkg

/* File: rtl/iocc_if.sv */
// Programmed I/O channel between host and countdown clock units.
// Assumes one clock shared by both ends; strobes are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

interface iocc_if;
    logic [1:0] unit;      // Channel-unit code of the addressed unit
    logic       cmd_stb;   // Command word output
    logic       stat_stb;  // Status word input
    logic       dout_stb;  // Data byte output
    logic       din_stb;   // Data byte input
    logic [7:0] wdata;     // Byte from host accumulator
    logic [7:0] rdata;     // Byte toward host accumulator
    logic       ack;       // Unit has taken the transfer
    logic       intr;      // Zero-count interrupt request

    modport device (
        input  unit, cmd_stb, stat_stb, dout_stb, din_stb, wdata,
        output rdata, ack, intr
    );

    modport host (
        output unit, cmd_stb, stat_stb, dout_stb, din_stb, wdata,
        input  rdata, ack, intr
    );
endinterface : iocc_if

`default_nettype wire

/* File: rtl/iocc_tick_sync.sv */
// Turns the free-running crystal clock into a one-cycle tick in clk.
// Assumes the crystal is far slower than clk (100 kHz against 40 MHz).
`timescale 1ns/10ps
`default_nettype none

module iocc_tick_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic xtal_clk,
    output logic      tick
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic tick_q;

    // Two-stage synchroniser; only sync2_q reads sync1_q
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= xtal_clk;
            sync2_q <= sync1_q;
        end
    end

    // Rising edge of the settled crystal level, once per crystal period
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            prev_q <= sync2_q;
            tick_q <= sync2_q & ~prev_q;
        end
    end

    assign tick = tick_q;
endmodule : iocc_tick_sync

`default_nettype wire

/* File: rtl/iocc_device.sv */
// Countdown clock unit on a programmed I/O channel: command, status,
// preset load, snapshot readout and zero-count interrupt.
// Assumes a host that issues one channel strobe at a time and a 100 kHz
// crystal on xtal_clk that keeps running whatever the host does.
`timescale 1ns/10ps
`default_nettype none
`include "iocc_consts.svh"

module iocc_device
    import iocc_pkg::*;
#(
    parameter logic [1:0] UNIT_CODE = 2'h0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        xtal_clk,
    iocc_if.device           chan,
    output logic [23:0]      count_value,
    output logic             counting
);
    // Byte count field of a four-bit configuration
    function automatic logic [1:0] bytes_of(input logic [`IOCC_CFG_W-1:0] cfg);
        bytes_of = cfg[`IOCC_CMD_BC_HI:`IOCC_CMD_BC_LO];
    endfunction : bytes_of

    // Byte number idx (1 = least significant) of a count value
    function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] idx);
        logic [23:0] shifted;
        shifted = '0;
        if (idx != 2'h0) begin
            shifted = v >> (`IOCC_BYTE_W * (int'(idx) - 1));
        end
        byte_of = shifted[`IOCC_BYTE_W-1:0];
    endfunction : byte_of

    logic                   tick;
    logic [`IOCC_CFG_W-1:0] cfg_q;
    logic [`IOCC_CFG_W-1:0] cfg_new;
    logic                   run_q;
    logic [23:0]            count_q;
    logic [23:0]            preset_q;
    logic [23:0]            preset_next;
    logic [1:0]             load_left_q;
    logic [23:0]            snap_q;
    logic [1:0]             snap_left_q;
    logic                   intr_q;
    logic                   ack_q;
    logic [7:0]             rdata_q;
    logic [23:0]            count_out_q;
    logic                   counting_q;
    logic                   sel;
    logic                   cmd_hit;
    logic                   stat_hit;
    logic                   dout_hit;
    logic                   din_hit;
    logic                   step;
    logic                   zero_evt;
    logic                   zero_irq;
    logic                   load_done;

    // Crystal tick, already in the clk domain
    iocc_tick_sync u_tick (
        .clk      (clk),
        .rst      (rst),
        .xtal_clk (xtal_clk),
        .tick     (tick)
    );

    // Channel decode: other units on the same channel are ignored
    assign sel      = (chan.unit == UNIT_CODE);
    assign cmd_hit  = chan.cmd_stb  & sel;
    assign stat_hit = chan.stat_stb & sel;
    assign dout_hit = chan.dout_stb & sel;
    assign din_hit  = chan.din_stb  & sel;

    // Configuration as it stands after this command word
    assign cfg_new = chan.wdata[`IOCC_CMD_SAMPLE] ? chan.wdata[`IOCC_CFG_W-1:0] : cfg_q;

    // Count events; the host's run state does not enter, only bit 7 does
    assign step     = tick & run_q & (count_q != `IOCC_COUNT_ZERO);
    assign zero_evt = step & (count_q == `IOCC_COUNT_ONE);
    assign zero_irq = zero_evt & cfg_q[`IOCC_CMD_INT_EN];

    // Preset as it will be after this data byte; upper bytes start at zero
    assign preset_next = {preset_q[15:0], chan.wdata};
    assign load_done   = dout_hit & (load_left_q == 2'h1);

    // Sampled configuration bits persist until a sampling command
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0;
        end else if (cmd_hit) begin
            cfg_q <= cfg_new;
        end
    end

    // Run/hold follows bit 7 of every command word
    always_ff @(posedge clk) begin
        if (rst) begin
            run_q <= 1'b0;
        end else if (cmd_hit) begin
            run_q <= chan.wdata[`IOCC_CMD_RUN];
        end
    end

    // Preset register and the bytes still expected for it
    always_ff @(posedge clk) begin
        if (rst) begin
            preset_q    <= '0;
            load_left_q <= '0;
        end else if (cmd_hit && chan.wdata[`IOCC_CMD_LOAD]) begin
            preset_q    <= '0;
            load_left_q <= bytes_of(cfg_new);
        end else if (dout_hit && load_left_q != 2'h0) begin
            preset_q    <= preset_next;
            load_left_q <= load_left_q - 2'h1;
        end
    end

    // Countdown; a completed load takes priority over a tick
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
        end else if (load_done) begin
            count_q <= preset_next;
        end else if (zero_evt && cfg_q[`IOCC_CMD_AUTO]) begin
            count_q <= preset_q;
        end else if (step) begin
            count_q <= count_q - `IOCC_COUNT_ONE;
        end
    end

    // Snapshot holding register and bytes left to read; the counter
    // itself is never touched here, so readout cannot slow the count
    always_ff @(posedge clk) begin
        if (rst) begin
            snap_q      <= '0;
            snap_left_q <= '0;
        end else if (cmd_hit && chan.wdata[`IOCC_CMD_SNAP]) begin
            snap_q      <= count_q;
            snap_left_q <= bytes_of(cfg_new);
        end else if (zero_irq) begin
            snap_left_q <= '0;
        end else if (din_hit && snap_left_q != 2'h0) begin
            snap_left_q <= snap_left_q - 2'h1;
        end
    end

    // Interrupt request: a status read acknowledges it, but a zero
    // event in the same cycle wins so that it is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            intr_q <= 1'b0;
        end else if (zero_irq) begin
            intr_q <= 1'b1;
        end else if (stat_hit) begin
            intr_q <= 1'b0;
        end else if (cmd_hit && !cfg_new[`IOCC_CMD_INT_EN]) begin
            intr_q <= 1'b0;
        end
    end

    // Answer: acknowledge every addressed strobe one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= cmd_hit | stat_hit | dout_hit | din_hit;
            rdata_q <= '0;
            if (stat_hit) begin
                rdata_q[`IOCC_ST_INTR] <= intr_q;
                rdata_q[`IOCC_ST_RUN]  <= run_q;
                rdata_q[`IOCC_ST_SNAP] <= (snap_left_q != 2'h0);
                rdata_q[`IOCC_ST_LOAD] <= (load_left_q != 2'h0);
                rdata_q[`IOCC_ST_ZERO] <= (count_q == `IOCC_COUNT_ZERO);
            end else if (din_hit) begin
                rdata_q <= byte_of(snap_q, snap_left_q);
            end
        end
    end

    // User-side mirrors of the counter, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            count_out_q <= '0;
            counting_q  <= 1'b0;
        end else begin
            count_out_q <= count_q;
            counting_q  <= run_q & (count_q != `IOCC_COUNT_ZERO);
        end
    end

    assign chan.ack    = ack_q;
    assign chan.rdata  = rdata_q;
    assign chan.intr   = intr_q;
    assign count_value = count_out_q;
    assign counting    = counting_q;
endmodule : iocc_device

`default_nettype wire

/* File: rtl/iocc_host.sv */
// Host end of the channel: software writes a transfer request over
// AXI4-Lite, the sequencer issues one channel strobe and waits for ack.
// Assumes exactly one unit answers each addressed strobe.
`timescale 1ns/10ps
`default_nettype none
`include "iocc_consts.svh"

module iocc_host
    import iocc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    iocc_if.host             chan
);
    logic                   awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]             bresp_q, rresp_q;
    logic [31:0]            rdata_q;
    logic [3:0]             awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   do_write, start;
    iocc_host_state_t       state_q;
    iocc_op_t               op_q;
    logic [1:0]             unit_q;
    logic [7:0]             out_q, last_q;
    logic                   done_q;
    logic                   cmd_q, stat_q, dout_q, din_q;

    // Write happens once address and data are both held
    assign do_write = !awready_q && !wready_q && !bvalid_q;
    // Strobes are judged as captured: the live wstrb is not valid once wvalid drops
    assign start    = do_write && awaddr_q == `IOCC_REG_XFER && state_q == hs_idle && wstrb_q != 4'h0;

    // Write channels: each taken on its own, released after the response
    always_ff @(posedge clk) begin
        if (rst) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `IOCC_RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (awready_q && s_axi_awvalid) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (wready_q && s_axi_wvalid) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                // Busy sequencer, any word but the transfer word, or no byte strobes refuses the write
                bresp_q  <= start ? `IOCC_RESP_OKAY : `IOCC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Read channel: one outstanding read, answered the cycle after
    always_ff @(posedge clk) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `IOCC_RESP_OKAY;
            rdata_q   <= '0;
        end else if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= '0;
            rresp_q   <= `IOCC_RESP_OKAY;
            if (s_axi_araddr == `IOCC_REG_STAT) begin
                rdata_q[7:0]           <= last_q;
                rdata_q[`IOCC_HS_BUSY] <= (state_q != hs_idle);
                rdata_q[`IOCC_HS_DONE] <= done_q;
                rdata_q[`IOCC_HS_INTR] <= chan.intr;
            end else if (s_axi_araddr == `IOCC_REG_XFER) begin
                rdata_q[7:0]                            <= out_q;
                rdata_q[`IOCC_XF_OP_LO+1:`IOCC_XF_OP_LO] <= op_q;
                rdata_q[`IOCC_XF_UNIT_LO+1:`IOCC_XF_UNIT_LO] <= unit_q;
            end else begin
                rresp_q <= `IOCC_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Channel sequencer: one strobe per request, then wait for the unit
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= hs_idle;
            op_q    <= command_output_transfer;
            unit_q  <= '0;
            out_q   <= '0;
        end else begin
            case (state_q)
                hs_idle: begin
                    if (start) begin
                        out_q   <= wdata_q[7:0];
                        op_q    <= iocc_op_t'(wdata_q[`IOCC_XF_OP_LO+1:`IOCC_XF_OP_LO]);
                        unit_q  <= wdata_q[`IOCC_XF_UNIT_LO+1:`IOCC_XF_UNIT_LO];
                        state_q <= hs_issue;
                    end
                end
                hs_issue: state_q <= hs_wait;
                hs_wait: begin
                    if (chan.ack) begin
                        state_q <= hs_idle;
                    end
                end
                default: state_q <= hs_idle;
            endcase
        end
    end

    // Strobes are flops, high for exactly the issue cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_q  <= 1'b0;
            stat_q <= 1'b0;
            dout_q <= 1'b0;
            din_q  <= 1'b0;
        end else begin
            cmd_q  <= start && wdata_q[`IOCC_XF_OP_LO+1:`IOCC_XF_OP_LO] == 2'(command_output_transfer);
            stat_q <= start && wdata_q[`IOCC_XF_OP_LO+1:`IOCC_XF_OP_LO] == 2'(status_input_transfer);
            dout_q <= start && wdata_q[`IOCC_XF_OP_LO+1:`IOCC_XF_OP_LO] == 2'(data_output_transfer);
            din_q  <= start && wdata_q[`IOCC_XF_OP_LO+1:`IOCC_XF_OP_LO] == 2'(data_input_transfer);
        end
    end

    // Result capture; a new request clears the done flag
    always_ff @(posedge clk) begin
        if (rst) begin
            last_q <= '0;
            done_q <= 1'b0;
        end else if (state_q == hs_wait && chan.ack) begin
            last_q <= chan.rdata;
            done_q <= 1'b1;
        end else if (start) begin
            done_q <= 1'b0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign chan.unit     = unit_q;
    assign chan.wdata    = out_q;
    assign chan.cmd_stb  = cmd_q;
    assign chan.stat_stb = stat_q;
    assign chan.dout_stb = dout_q;
    assign chan.din_stb  = din_q;
endmodule : iocc_host

`default_nettype wire

/* File: verif/iocc_chan_sva.sv */
// Checker for the channel between the host end and one countdown unit.
// Assumes one clock, a synchronous active-high reset, the unit at UNIT_CODE.
`timescale 1ns/10ps
`default_nettype none
`include "iocc_consts.svh"

module iocc_chan_sva #(
    parameter logic [1:0] UNIT_CODE = 2'h0
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [1:0] unit,
    input wire logic       cmd_stb,
    input wire logic       stat_stb,
    input wire logic       dout_stb,
    input wire logic       din_stb,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       intr
);
    // Any strobe, and a strobe aimed at this unit
    wire logic any_stb = cmd_stb | stat_stb | dout_stb | din_stb;
    wire logic mine    = any_stb & (unit == UNIT_CODE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A request to this unit; a status request with its answer
    sequence s_req;
        any_stb && unit == UNIT_CODE;
    endsequence
    sequence s_stat_ans;
        stat_stb && unit == UNIT_CODE ##1 ack;
    endsequence

    a_ack_follows: assert property (s_req |=> ack) else $error("ack missing");
    a_ack_cause: assert property (ack |-> $past(mine)) else $error("ack without strobe");
    a_foreign_unit: assert property (any_stb && unit != UNIT_CODE |=> !ack) else $error("foreign ack");
    a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
    a_rdata_idle: assert property (!ack |-> rdata == 8'h00) else $error("rdata idle");
    a_status_intr: assert property (s_stat_ans |-> rdata[`IOCC_ST_INTR] == $past(intr))
        else $error("status intr bit");
    a_intr_clear: assert property ($fell(intr) |-> $past(mine && !dout_stb && !din_stb))
        else $error("intr dropped");
    a_stb_spacing: assert property (any_stb |=> !any_stb [*2]) else $error("strobes too close");
    a_one_stb: assert property ($onehot0({cmd_stb, stat_stb, dout_stb, din_stb})) else $error("two strobes");
    a_wdata_stands: assert property ($changed(wdata) |-> any_stb) else $error("wdata moved");
endmodule : iocc_chan_sva

`default_nettype wire

/* File: verif/io_channel_countdown_clock_test.sv */
// Bench: an AXI4-Lite master drives the host end, which talks to one unit.
// Assumes a 40 MHz clk and a free-running 100 kHz crystal made here.
`timescale 1ns/10ps
`default_nettype none

module io_channel_countdown_clock_test import iocc_pkg::*;;
    localparam logic [1:0] UNIT = 2'h2;
    logic        clk, rst, xtal_clk, counting;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, st;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [23:0] count_value;
    logic [7:0]  g;
    int          failures, checks_done, cycles;

    iocc_if iocc_if_i ();
    iocc_host iocc_host_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .chan(iocc_if_i));
    iocc_device #(.UNIT_CODE(UNIT)) iocc_device_i (.clk, .rst, .xtal_clk, .chan(iocc_if_i),
        .count_value, .counting);
    iocc_chan_sva #(.UNIT_CODE(UNIT)) iocc_chan_sva_i (.clk, .rst, .unit(iocc_if_i.unit),
        .cmd_stb(iocc_if_i.cmd_stb), .stat_stb(iocc_if_i.stat_stb), .dout_stb(iocc_if_i.dout_stb),
        .din_stb(iocc_if_i.din_stb), .wdata(iocc_if_i.wdata), .rdata(iocc_if_i.rdata),
        .ack(iocc_if_i.ack), .intr(iocc_if_i.intr));

    // Bus clock, and a crystal with no phase relation to it
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        xtal_clk = 1'b0;
        #3.3;
        forever #5000 xtal_clk = ~xtal_clk;
    end

    // Hang guard: far beyond the few crystal ticks the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rr);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : axi_rd

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_rd(a, st, r);
        chk(st, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd_chk

    // One channel transfer; waits for the done flag, keeps the byte in g
    task automatic xfer(input iocc_op_t op, input logic [7:0] b);
        axi_wr(4'h0, {20'h0, UNIT, op, b}, 2'h0);
        do axi_rd(4'h4, st, r); while (!st[9]);
        g = st[7:0];
    endtask : xfer

    task automatic din(input logic [7:0] e);
        xfer(data_input_transfer, 8'h00);
        chk({24'h0, g}, {24'h0, e});
    endtask : din

    task automatic wait_intr;
        do axi_rd(4'h4, st, r); while (!st[10]);
    endtask : wait_intr

    task automatic end_sim;
        $display("Checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = 11'h000;
        {s_axi_wdata, s_axi_wstrb, s_axi_bready, s_axi_rready} = {32'h0, 4'hf, 2'h3};
        {failures, checks_done, cycles} = 96'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(4'h4, 32'h0, 2'h0);
        rd_chk(4'h8, 32'h0, 2'h2);
        axi_wr(4'h4, 32'h0, 2'h2);
        // Three-byte preset with interrupt, holding at zero
        xfer(command_output_transfer, 8'h5d);
        xfer(data_output_transfer, 8'h00);
        xfer(data_output_transfer, 8'h00);
        xfer(data_output_transfer, 8'h03);
        xfer(command_output_transfer, 8'h80);
        axi_rd(4'h4, st, r);
        chk({31'h0, st[10]}, 32'h0);
        wait_intr();
        xfer(status_input_transfer, 8'h00);
        chk({24'h0, g}, 32'h13);
        axi_rd(4'h4, st, r);
        chk({31'h0, st[10]}, 32'h0);
        xfer(command_output_transfer, 8'ha0);
        din(8'h00);
        din(8'h00);
        din(8'h00);
        // Two-byte preset while frozen
        xfer(command_output_transfer, 8'h5a);
        xfer(data_output_transfer, 8'h12);
        xfer(data_output_transfer, 8'h34);
        rd_chk(4'h0, 32'h00000a34, 2'h0);
        repeat (900) @(posedge clk);
        chk({8'h0, count_value}, 32'h1234);
        chk({31'h0, counting}, 32'h0);
        xfer(command_output_transfer, 8'h3e);
        din(8'h00);
        din(8'h12);
        din(8'h34);
        din(8'h00);
        // Auto restart; interrupt ends an unfinished readout
        xfer(command_output_transfer, 8'h5f);
        xfer(data_output_transfer, 8'h00);
        xfer(data_output_transfer, 8'h00);
        xfer(data_output_transfer, 8'h02);
        xfer(command_output_transfer, 8'ha0);
        din(8'h00);
        din(8'h00);
        wait_intr();
        chk({31'h0, counting}, 32'h1);
        din(8'h00);
        xfer(command_output_transfer, 8'ha0);
        din(8'h00);
        din(8'h00);
        din(8'h02);
        // Unit code nobody answers, then reset in mid-run
        axi_wr(4'h0, 32'h0, 2'h0);
        axi_wr(4'h0, 32'h0, 2'h2);
        repeat (20) @(posedge clk);
        axi_rd(4'h4, st, r);
        chk({31'h0, st[8]}, 32'h1);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(4'h4, 32'h0, 2'h0);
        end_sim();
    end
endmodule : io_channel_countdown_clock_test

`default_nettype wire
